// ==== pkg/omcr_defs.vh ====
`ifndef OMCR_DEFS_VH
`define OMCR_DEFS_VH

// register addresses on the 8-bit register port
`define OMCR_ADDR_PARAM_FIRST 8'h00
`define OMCR_ADDR_PARAM_LAST 8'h08
`define OMCR_ADDR_CAPTURE_INDEX 8'h09
`define OMCR_ADDR_SOFT_RESET 8'h0a
`define OMCR_ADDR_MODE_SETTING 8'h0b
`define OMCR_ADDR_ACQ_CONTROL 8'h0c
`define OMCR_ADDR_TUNER_POLARITY 8'h0d
`define OMCR_ADDR_STATUS 8'h3e

// parameter block size and capture index range
`define OMCR_PARAM_BYTES 4'h9
`define OMCR_INDEX_MAX 8'h08

// soft reset trigger values
`define OMCR_SRST_LOW 8'h00
`define OMCR_SRST_HIGH 8'h01

// reset values
`define OMCR_MODE_SETTING_RST 8'h12
`define OMCR_ACQ_CONTROL_RST 8'h1c
`define OMCR_TUNER_POLARITY_RST 8'h75
`define OMCR_PARAM_BYTE_RST 8'h00

// transmission_mode_setting fields
`define OMCR_CODE_RATE_MSB 7
`define OMCR_CODE_RATE_LSB 4
`define OMCR_GUARD_MSB 3
`define OMCR_GUARD_LSB 2
`define OMCR_CONST_MSB 1
`define OMCR_CONST_LSB 0

// acquisition_control fields
`define OMCR_AUTO_CHANGEOVER_BIT 3
`define OMCR_AUTO_PARAM_LOAD_BIT 2
`define OMCR_FREQ_ACQ_BIT 1
`define OMCR_TIMING_ACQ_BIT 0

// tuner_interface_polarity fields
`define OMCR_FINE_TIMING_EN_BIT 7
`define OMCR_FREQ_CORR_POL_BIT 6
`define OMCR_GAIN_CTRL_POL_BIT 5
`define OMCR_SIDEBAND_BIT 2
`define OMCR_SAMPLE_FORMAT_BIT 1
`define OMCR_OSC_CTRL_POL_BIT 0

`endif

// ==== hdl/omcr_capture_tracker.v ====
`timescale 1ns/1ps
`include "omcr_defs.vh"

// counts the parameter byte reads that close a capture burst
module omcr_capture_tracker
(
	input wire clk_sys, // system clock
	input wire rst_n, // synchronous reset, active low
	input wire index_wr, // write strobe for the capture index
	input wire [7:0] index_val, // value written to the capture index
	input wire param_rd, // read of one parameter byte
	output reg frozen_reg, // automatic refresh held off
	output reg [3:0] remaining_reg // parameter reads still expected
);

	// arm on a valid index, count down on each byte read
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			frozen_reg <= 1'b0;
			remaining_reg <= 4'h0;
		end
		else if (index_wr && (index_val <= `OMCR_INDEX_MAX))
		begin
			frozen_reg <= 1'b1;
			remaining_reg <= `OMCR_PARAM_BYTES - index_val[3:0];
		end
		else if (frozen_reg && param_rd)
		begin
			remaining_reg <= remaining_reg - 4'h1;
			if (remaining_reg == 4'h1)
				frozen_reg <= 1'b0;
		end
	end

endmodule // omcr_capture_tracker

// ==== hdl/omcr_soft_reset_seq.v ====
`timescale 1ns/1ps
`include "omcr_defs.vh"

// spots the zero, one, zero write sequence on the soft reset register
module omcr_soft_reset_seq
(
	input wire clk_sys, // system clock
	input wire rst_n, // synchronous reset, active low
	input wire trig_wr, // write strobe for the trigger register
	input wire [7:0] trig_val, // value written
	output reg loop_restart_reg // one-cycle restart of the control loops
);

	localparam ST_IDLE = 2'b00;
	localparam ST_SEEN_0 = 2'b01;
	localparam ST_SEEN_01 = 2'b10;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg fire_next;

	// next state from each trigger write
	always @*
	begin
		state_next = state_reg;
		fire_next = 1'b0;
		if (trig_wr)
		begin
			case (state_reg)
				ST_SEEN_0:
					if (trig_val == `OMCR_SRST_HIGH)
						state_next = ST_SEEN_01;
					else if (trig_val != `OMCR_SRST_LOW)
						state_next = ST_IDLE;
				ST_SEEN_01:
					if (trig_val == `OMCR_SRST_LOW)
					begin
						fire_next = 1'b1;
						state_next = ST_SEEN_0;
					end
					else
						state_next = ST_IDLE;
				default:
					if (trig_val == `OMCR_SRST_LOW)
						state_next = ST_SEEN_0;
					else
						state_next = ST_IDLE;
			endcase
		end
	end

	// sequence state and restart pulse
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_IDLE;
			loop_restart_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			loop_restart_reg <= fire_next;
		end
	end

endmodule // omcr_soft_reset_seq

// ==== hdl/omcr_top.v ====
// Contract
// - index write 0..8 freezes parameter refresh
// - expected read count is nine minus index
// - refresh resumes after last expected read
// - writes 0,1,0 restart demodulator loops
// - soft reset keeps all programmed registers
// - mode 0 holds rate, guard, constellation
// - mode 0 writable only with auto load off
// - device may reload mode 0 itself
// - auto load bit picks decoded or manual
// - auto load bit resets to one
// - auto changeover bit, reset one
// - manual timing mode ignored in auto
// - manual frequency mode ignored in auto
// - oscillator control polarity, reset one
// - converter sample format, reset two's complement
// - sideband select, reset lower
// - gain control polarity, reset one
// - frequency correction polarity, reset one
// - fine timing loop drives oscillator, reset off
`timescale 1ns/1ps
`include "omcr_defs.vh"

module omcr_top
(
	input wire clk_sys, // system clock, 100 MHz
	input wire rst_n, // synchronous reset, active low
	// register port
	input wire [7:0] reg_addr, // register address
	input wire [7:0] reg_wdata, // write data
	input wire reg_wr, // write strobe, one cycle
	input wire reg_rd, // read strobe, one cycle
	output reg [7:0] reg_rdata, // read data, cycle after strobe
	// decoded transmission parameters from the demodulator
	input wire [71:0] param_in, // nine parameter bytes, byte 0 low
	input wire param_in_valid, // new parameter block present
	input wire [3:0] dec_code_rate, // decoded code rate
	input wire [1:0] dec_guard, // decoded guard interval
	input wire [1:0] dec_const, // decoded constellation
	input wire dec_valid, // decoded settings valid
	// automatic acquisition state from the sync loops
	input wire auto_timing_fine, // time sync loop asks for fine mode
	input wire auto_freq_fine, // frequency loop asks for fine mode
	// settings to the demodulator
	output reg [3:0] code_rate, // active code rate
	output reg [1:0] guard_sel, // active guard interval
	output reg [1:0] const_sel, // active constellation
	output reg auto_param_load, // settings follow decoded values
	output reg auto_changeover_en, // automatic coarse to fine
	output reg timing_acq_mode, // 1 fine, 0 coarse time sync
	output reg freq_acq_mode, // 1 fine, 0 coarse frequency sync
	output reg fine_timing_loop_en, // timing loop drives oscillator
	output reg freq_corr_polarity, // 1 decreasing frequency
	output reg gain_ctrl_polarity, // 1 falling voltage raises gain
	output reg sideband_sel, // 1 lower sideband
	output reg sample_format_sel, // 1 offset binary
	output reg osc_ctrl_polarity, // 1 falling voltage raises frequency
	output reg loop_restart, // one-cycle restart of control loops
	output reg param_frozen // parameter refresh held off
);

	// programmed registers
	reg [7:0] mode_setting_reg;
	reg [7:0] acq_control_reg;
	reg [7:0] tuner_polarity_reg;

	// captured parameter bytes
	reg [7:0] param_mem [0:8];

	// address decode strobes
	reg wr_index;
	reg wr_srst;
	reg wr_mode;
	reg wr_acq;
	reg wr_tuner;
	reg rd_param;

	// capture tracker and soft reset sequence results
	wire frozen;
	wire [3:0] remaining;
	wire restart_pulse;

	// read data next value
	reg [7:0] rdata_next;

	// acquisition control register fields
	wire auto_load_bit;
	wire auto_sync_bit;
	wire manual_timing_bit;
	wire manual_freq_bit;

	assign auto_load_bit = acq_control_reg[`OMCR_AUTO_PARAM_LOAD_BIT];
	assign auto_sync_bit = acq_control_reg[`OMCR_AUTO_CHANGEOVER_BIT];
	assign manual_timing_bit = acq_control_reg[`OMCR_TIMING_ACQ_BIT];
	assign manual_freq_bit = acq_control_reg[`OMCR_FREQ_ACQ_BIT];

	// tuner polarity register fields
	wire fine_timing_bit;
	wire freq_corr_bit;
	wire gain_ctrl_bit;
	wire sideband_bit;
	wire sample_format_bit;
	wire osc_ctrl_bit;

	assign fine_timing_bit = tuner_polarity_reg[`OMCR_FINE_TIMING_EN_BIT];
	assign freq_corr_bit = tuner_polarity_reg[`OMCR_FREQ_CORR_POL_BIT];
	assign gain_ctrl_bit = tuner_polarity_reg[`OMCR_GAIN_CTRL_POL_BIT];
	assign sideband_bit = tuner_polarity_reg[`OMCR_SIDEBAND_BIT];
	assign sample_format_bit = tuner_polarity_reg[`OMCR_SAMPLE_FORMAT_BIT];
	assign osc_ctrl_bit = tuner_polarity_reg[`OMCR_OSC_CTRL_POL_BIT];

	// reset images of the programmed registers, sliced into output fields
	wire [7:0] mode_rst_val;
	wire [7:0] acq_rst_val;
	wire [7:0] tuner_rst_val;

	assign mode_rst_val = `OMCR_MODE_SETTING_RST;
	assign acq_rst_val = `OMCR_ACQ_CONTROL_RST;
	assign tuner_rst_val = `OMCR_TUNER_POLARITY_RST;

	// acquisition mode next values
	reg timing_mode_next;
	reg freq_mode_next;

	// parameter store refresh enable, held off while a capture is open
	wire param_refresh;

	assign param_refresh = param_in_valid && !frozen;

	// status image: remaining reads and the active acquisition modes
	wire [7:0] status_val;

	assign status_val = {2'h0, freq_acq_mode, timing_acq_mode, remaining};

	// write decode
	always @*
	begin
		wr_index = 1'b0;
		wr_srst = 1'b0;
		wr_mode = 1'b0;
		wr_acq = 1'b0;
		wr_tuner = 1'b0;
		if (reg_wr)
		begin
			if (reg_addr == `OMCR_ADDR_CAPTURE_INDEX)
				wr_index = 1'b1;
			else if (reg_addr == `OMCR_ADDR_SOFT_RESET)
				wr_srst = 1'b1;
			else if (reg_addr == `OMCR_ADDR_MODE_SETTING)
				wr_mode = 1'b1;
			else if (reg_addr == `OMCR_ADDR_ACQ_CONTROL)
				wr_acq = 1'b1;
			else if (reg_addr == `OMCR_ADDR_TUNER_POLARITY)
				wr_tuner = 1'b1;
		end
	end

	// parameter byte reads, counted down by the capture tracker
	always @*
	begin
		rd_param = 1'b0;
		if (reg_rd && (reg_addr <= `OMCR_ADDR_PARAM_LAST))
			rd_param = 1'b1;
	end

	// counts the reads of a capture burst
	omcr_capture_tracker u_capture
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.index_wr(wr_index),
		.index_val(reg_wdata),
		.param_rd(rd_param),
		.frozen_reg(frozen),
		.remaining_reg(remaining)
	);

	// watches the soft reset trigger register
	omcr_soft_reset_seq u_srst
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.trig_wr(wr_srst),
		.trig_val(reg_wdata),
		.loop_restart_reg(restart_pulse)
	);

	// parameter bytes refresh only while no capture is open
	genvar gi;
	generate
		for (gi = 0; gi < 9; gi = gi + 1)
		begin : g_param
			always @(posedge clk_sys)
			begin
				if (!rst_n)
					param_mem[gi] <= `OMCR_PARAM_BYTE_RST;
				else if (param_refresh)
					param_mem[gi] <= param_in[gi*8 +: 8];
			end
		end
	endgenerate

	// mode setting: manual write or reload from decoded values
	// soft reset is not wired here, so contents survive it
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			mode_setting_reg <= `OMCR_MODE_SETTING_RST;
		else if (wr_mode && !auto_load_bit)
			mode_setting_reg <= reg_wdata;
		else if (auto_load_bit && dec_valid)
			mode_setting_reg <= {dec_code_rate, dec_guard, dec_const};
	end

	// acquisition control, write only
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			acq_control_reg <= `OMCR_ACQ_CONTROL_RST;
		else if (wr_acq)
			acq_control_reg <= reg_wdata;
	end

	// tuner interface polarity, write only
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			tuner_polarity_reg <= `OMCR_TUNER_POLARITY_RST;
		else if (wr_tuner)
			tuner_polarity_reg <= reg_wdata;
	end

	// acquisition mode: loop request with changeover on, manual bit otherwise
	always @*
	begin
		timing_mode_next = manual_timing_bit;
		freq_mode_next = manual_freq_bit;
		if (auto_sync_bit)
		begin
			timing_mode_next = auto_timing_fine;
			freq_mode_next = auto_freq_fine;
		end
	end

	// modulation settings from the mode setting register
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			code_rate <= mode_rst_val[`OMCR_CODE_RATE_MSB:`OMCR_CODE_RATE_LSB];
			guard_sel <= mode_rst_val[`OMCR_GUARD_MSB:`OMCR_GUARD_LSB];
			const_sel <= mode_rst_val[`OMCR_CONST_MSB:`OMCR_CONST_LSB];
		end
		else
		begin
			code_rate <= mode_setting_reg[`OMCR_CODE_RATE_MSB:`OMCR_CODE_RATE_LSB];
			guard_sel <= mode_setting_reg[`OMCR_GUARD_MSB:`OMCR_GUARD_LSB];
			const_sel <= mode_setting_reg[`OMCR_CONST_MSB:`OMCR_CONST_LSB];
		end
	end

	// acquisition settings; a stale manual bit has no effect in auto mode
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			auto_param_load <= acq_rst_val[`OMCR_AUTO_PARAM_LOAD_BIT];
			auto_changeover_en <= acq_rst_val[`OMCR_AUTO_CHANGEOVER_BIT];
			timing_acq_mode <= acq_rst_val[`OMCR_TIMING_ACQ_BIT];
			freq_acq_mode <= acq_rst_val[`OMCR_FREQ_ACQ_BIT];
		end
		else
		begin
			auto_param_load <= auto_load_bit;
			auto_changeover_en <= auto_sync_bit;
			timing_acq_mode <= timing_mode_next;
			freq_acq_mode <= freq_mode_next;
		end
	end

	// tuner interface polarities
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			fine_timing_loop_en <= tuner_rst_val[`OMCR_FINE_TIMING_EN_BIT];
			freq_corr_polarity <= tuner_rst_val[`OMCR_FREQ_CORR_POL_BIT];
			gain_ctrl_polarity <= tuner_rst_val[`OMCR_GAIN_CTRL_POL_BIT];
			sideband_sel <= tuner_rst_val[`OMCR_SIDEBAND_BIT];
			sample_format_sel <= tuner_rst_val[`OMCR_SAMPLE_FORMAT_BIT];
			osc_ctrl_polarity <= tuner_rst_val[`OMCR_OSC_CTRL_POL_BIT];
		end
		else
		begin
			fine_timing_loop_en <= fine_timing_bit;
			freq_corr_polarity <= freq_corr_bit;
			gain_ctrl_polarity <= gain_ctrl_bit;
			sideband_sel <= sideband_bit;
			sample_format_sel <= sample_format_bit;
			osc_ctrl_polarity <= osc_ctrl_bit;
		end
	end

	// restart pulse out, one cycle per completed sequence
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			loop_restart <= 1'b0;
		else
			loop_restart <= restart_pulse;
	end

	// capture flag out, one cycle behind the tracker
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			param_frozen <= 1'b0;
		else
			param_frozen <= frozen;
	end

	// read multiplexer; write-only and unmapped addresses read zero
	always @*
	begin
		rdata_next = 8'h00;
		if (reg_rd)
		begin
			if (reg_addr <= `OMCR_ADDR_PARAM_LAST)
				rdata_next = param_mem[reg_addr[3:0]];
			else if (reg_addr == `OMCR_ADDR_MODE_SETTING)
				rdata_next = mode_setting_reg;
			else if (reg_addr == `OMCR_ADDR_STATUS)
				rdata_next = status_val;
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= rdata_next;
	end

endmodule // omcr_top

// ==== tb/omcr_top_sva.sv ====
`timescale 1ns/1ps
module omcr_top_sva
(
	input wire clk_sys, // clock
	input wire rst_n, // reset
	input wire [7:0] reg_addr, // address
	input wire [7:0] reg_wdata, // write data
	input wire reg_wr, // write strobe
	input wire reg_rd, // read strobe
	input wire auto_timing_fine, // loop ask
	input wire auto_freq_fine, // loop ask
	input wire [3:0] code_rate, // rate
	input wire auto_param_load, // auto load
	input wire auto_changeover_en, // auto switch
	input wire timing_acq_mode, // timing mode
	input wire freq_acq_mode, // freq mode
	input wire loop_restart, // restart
	input wire param_frozen // frozen
);
	// one clock domain
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// index write freezes refresh
	a_index_freeze: assert property (reg_wr && reg_addr == 8'h09 &&
		reg_wdata <= 8'h08 ##1 !reg_rd |=> param_frozen)
		else $error("index write did not freeze");
	// freeze only ends after a parameter read
	a_unfreeze_cause: assert property ($past(rst_n) && $fell(param_frozen) |->
		$past(reg_rd, 2) && $past(reg_addr, 2) <= 8'h08)
		else $error("freeze ended without a read");
	// manual mode write reaches the code rate output
	a_mode_manual: assert property (!auto_param_load && !$past(reg_wr) && reg_wr &&
		reg_addr == 8'h0b |-> ##2 {code_rate, 4'h0} == ($past(reg_wdata, 2) & 8'hf0))
		else $error("manual rate not applied");
	// auto changeover follows loop requests
	a_timing_auto: assert property ($past(rst_n) && auto_changeover_en &&
		$past(auto_changeover_en) |-> timing_acq_mode == $past(auto_timing_fine))
		else $error("timing mode not from loop");
	a_freq_auto: assert property ($past(rst_n) && auto_changeover_en &&
		$past(auto_changeover_en) |-> freq_acq_mode == $past(auto_freq_fine))
		else $error("freq mode not from loop");
	// zero one zero gives a restart
	a_restart_seq: assert property (reg_wr && reg_addr == 8'h0a && reg_wdata == 8'h00
		##1 reg_wr && reg_addr == 8'h0a && reg_wdata == 8'h01
		##1 reg_wr && reg_addr == 8'h0a && reg_wdata == 8'h00 |-> ##2 loop_restart)
		else $error("no restart after sequence");
	a_restart_pulse: assert property (loop_restart |=> !loop_restart)
		else $error("restart longer than one cycle");
	// auto bits set out of reset
	a_reset_auto: assert property ($rose(rst_n) |-> auto_param_load && auto_changeover_en)
		else $error("auto bits not set at reset");
	// main scenarios
	c_freeze: cover property ($fell(param_frozen));
	c_restart: cover property (loop_restart);
	c_manual: cover property (!auto_param_load && reg_wr && reg_addr == 8'h0b);
endmodule // omcr_top_sva

bind omcr_top omcr_top_sva u_sva (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.auto_timing_fine, .auto_freq_fine, .code_rate, .auto_param_load, .auto_changeover_en,
	.timing_acq_mode, .freq_acq_mode, .loop_restart, .param_frozen);

// ==== tb/omcr_top_bench.sv ====
`timescale 1ns/1ps
module omcr_top_bench;
	reg clk_sys = 0;
	reg rst_n = 0;
	reg [7:0] reg_addr = 0;
	reg [7:0] reg_wdata = 0;
	reg reg_wr = 0;
	reg reg_rd = 0;
	reg [71:0] param_in = 0;
	reg param_in_valid = 0;
	reg [3:0] dec_code_rate = 0;
	reg [1:0] dec_guard = 0;
	reg [1:0] dec_const = 0;
	reg dec_valid = 0;
	reg auto_timing_fine = 0;
	reg auto_freq_fine = 0;
	wire [7:0] reg_rdata;
	wire [3:0] code_rate;
	wire [1:0] guard_sel;
	wire [1:0] const_sel;
	wire auto_param_load, auto_changeover_en, timing_acq_mode, freq_acq_mode;
	wire fine_timing_loop_en, freq_corr_polarity, gain_ctrl_polarity, sideband_sel;
	wire sample_format_sel, osc_ctrl_polarity, loop_restart, param_frozen;
	wire [7:0] pol = {2'b00, fine_timing_loop_en, freq_corr_polarity, gain_ctrl_polarity,
		sideband_sel, sample_format_sel, osc_ctrl_polarity};
	localparam [47:0] acq_tab = 48'h1fa1f5116129;
	localparam [39:0] wo = 40'h090a0c0d20;
	integer mismatches = 0;
	integer n_checks = 0;
	integer n_restart = 0;
	integer i, k;
	reg [7:0] a;
	reg [11:0] e;
	// clock and restart pulse counter
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		if (loop_restart === 1'b1)
			n_restart <= n_restart + 1;
	end
	omcr_top dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.param_in, .param_in_valid, .dec_code_rate, .dec_guard, .dec_const, .dec_valid,
		.auto_timing_fine, .auto_freq_fine, .code_rate, .guard_sel, .const_sel,
		.auto_param_load, .auto_changeover_en, .timing_acq_mode, .freq_acq_mode,
		.fine_timing_loop_en, .freq_corr_polarity, .gain_ctrl_polarity, .sideband_sel,
		.sample_format_sel, .osc_ctrl_polarity, .loop_restart, .param_frozen);
	// nine parameter bytes, b picks the pattern
	function [71:0] blk(input b);
		integer n;
		begin
			for (n = 0; n < 9; n = n + 1)
				blk[8*n +: 8] = {b, 3'b001, n[3:0]};
		end
	endfunction
	task chk(input [7:0] got, input [7:0] exp);
	begin
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task step(input integer n);
		repeat (n) @(posedge clk_sys);
	endtask
	// bus write, hold keeps the strobe for a back to back write
	task wr(input [7:0] ad, input [7:0] d, input hold);
	begin
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk_sys);
		if (!hold)
		begin
			reg_wr <= 1'b0;
			@(posedge clk_sys);
		end
	end
	endtask
	task rd(input [7:0] ad, input [7:0] x, input [7:0] m);
	begin
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & m, x & m);
		@(posedge clk_sys);
	end
	endtask
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task t_reset;
	begin
		#1;
		chk({code_rate, guard_sel, const_sel}, 8'h12);
		chk({4'h0, auto_changeover_en, auto_param_load, freq_acq_mode, timing_acq_mode}, 8'h0c);
		chk(pol, 8'h1d);
		@(posedge clk_sys);
		rd(8'h0b, 8'h12, 8'hff);
		for (i = 0; i < 5; i = i + 1)
			rd(wo[8*i +: 8], 8'h00, 8'hff);
		$display("reset done");
	end
	endtask
	task t_capture;
	begin
		param_in_valid <= 1'b1;
		wr(8'h09, 8'h09, 1'b0);
		#1;
		chk({7'h0, param_frozen}, 8'h00);
		@(posedge clk_sys);
		for (i = 0; i < 9; i = i + 1)
		begin
			param_in <= blk(1'b0);
			step(2);
			wr(8'h09, i[7:0], 1'b0);
			param_in <= blk(1'b1);
			rd(8'h3e, 8'h09 - i[7:0], 8'h0f);
			for (k = 0; k < 9 - i; k = k + 1)
			begin
				a = 8'((k * 5) % 9);
				#1;
				chk({7'h0, param_frozen}, 8'h01);
				@(posedge clk_sys);
				rd(a, {4'h1, a[3:0]}, 8'hff);
			end
			#1;
			chk({7'h0, param_frozen}, 8'h00);
			@(posedge clk_sys);
			rd(8'h04, 8'h94, 8'hff);
		end
		$display("capture done");
	end
	endtask
	task t_mode;
	begin
		dec_code_rate <= 4'h3;
		dec_guard <= 2'h2;
		dec_const <= 2'h1;
		dec_valid <= 1'b1;
		@(posedge clk_sys);
		dec_valid <= 1'b0;
		step(2);
		rd(8'h0b, 8'h39, 8'hff);
		wr(8'h0b, 8'h40, 1'b0);
		rd(8'h0b, 8'h39, 8'hff);
		wr(8'h0c, 8'h18, 1'b0);
		for (i = 0; i < 5; i = i + 1)
		begin
			a = {i[3:0], i[1:0], 2'(i % 3)};
			wr(8'h0b, a, 1'b0);
			rd(8'h0b, a, 8'hff);
			#1;
			chk({code_rate, guard_sel, const_sel}, a);
			@(posedge clk_sys);
		end
		dec_valid <= 1'b1;
		@(posedge clk_sys);
		dec_valid <= 1'b0;
		step(2);
		rd(8'h0b, 8'h41, 8'hff);
		wr(8'h0c, 8'h1c, 1'b0);
		$display("mode done");
	end
	endtask
	task t_acq;
	begin
		for (i = 0; i < 4; i = i + 1)
		begin
			e = acq_tab[12*(3-i) +: 12];
			auto_timing_fine <= e[3];
			auto_freq_fine <= e[2];
			wr(8'h0c, e[11:4], 1'b0);
			step(1);
			#1;
			chk({4'h0, auto_changeover_en, auto_param_load, timing_acq_mode, freq_acq_mode},
				{4'h0, e[7], e[6], e[1], e[0]});
			@(posedge clk_sys);
		end
		wr(8'h0c, 8'h1c, 1'b0);
		$display("acq done");
	end
	endtask
	task t_polar;
	begin
		for (i = 0; i < 8; i = i + 1)
		begin
			if (i != 3 && i != 4)
			begin
				a = 8'h10 | (8'h01 << i);
				wr(8'h0d, a, 1'b0);
				#1;
				chk(pol, {2'b00, a[7:5], a[2:0]});
				@(posedge clk_sys);
			end
		end
		$display("polarity done");
	end
	endtask
	task t_srst;
	begin
		k = n_restart;
		wr(8'h0a, 8'h00, 1'b1);
		wr(8'h0a, 8'h01, 1'b1);
		wr(8'h0a, 8'h00, 1'b0);
		step(3);
		chk(8'(n_restart - k), 8'h01);
		rd(8'h0b, 8'h41, 8'hff);
		#1;
		chk(pol, 8'h20);
		@(posedge clk_sys);
		wr(8'h0a, 8'h00, 1'b1);
		wr(8'h0a, 8'h02, 1'b1);
		wr(8'h0a, 8'h00, 1'b0);
		step(3);
		chk(8'(n_restart - k), 8'h01);
		$display("soft reset done");
	end
	endtask
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset;
		t_capture;
		t_mode;
		t_acq;
		t_polar;
		t_srst;
		end_sim;
	end
	// hang guard
	initial
	begin
		#300000;
		mismatches = mismatches + 1;
		end_sim;
	end
endmodule // omcr_top_bench
